/* File: common/stx_pkg.sv */
package stx_pkg;

  // Default widths of the core datapath
  localparam int DATA_W  = 8;
  localparam int PROG_W  = 14;
  localparam int PROG_AW = 11;
  localparam int PAGE_W  = 3;
  localparam int MEM_AW  = 7;
  localparam int BIT_W   = 3;

  // Reset values
  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic [7:0] HIGH_RESET  = 8'h00;
  localparam logic       ZERO_RESET  = 1'b0;

  // Operation codes presented by the instruction decoder
  typedef enum logic [3:0] {
    OP_IDLE             = 4'h0,
    OP_NIBBLE_SWAP_ACC  = 4'h1,
    OP_SKIP_IF_ZERO     = 4'h2,
    OP_MOVE_SKIP_ZERO   = 4'h3,
    OP_SKIP_BIT_CLEAR   = 4'h4,
    OP_TABLE_READ_CUR   = 4'h5,
    OP_TABLE_READ_LAST  = 4'h6,
    OP_XOR_ACC_MEM      = 4'h7,
    OP_XOR_TO_MEMORY    = 4'h8,
    OP_XOR_IMM          = 4'h9
  } stx_op_t;

  // Execution sequencer, Gray coded along idle -> dummy and idle -> table
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_DUMMY = 2'h1,
    ST_TABLE = 2'h2
  } stx_state_t;

endpackage

/* File: common/stx_op_if.sv */
`timescale 1ns/100ps
interface stx_op_if #(
  parameter int DATA_W = stx_pkg::DATA_W,
  parameter int BIT_W  = stx_pkg::BIT_W
);
  stx_pkg::stx_op_t    op;
  logic [DATA_W-1:0]   mem_byte;
  logic [DATA_W-1:0]   acc;
  logic [DATA_W-1:0]   imm;
  logic [BIT_W-1:0]    bit_sel;
  logic [DATA_W-1:0]   result;
  logic                result_zero;
  logic                skip;
  logic                writes_acc;
  logic                writes_mem;
  logic                writes_zero;

  modport exec (
    output op, mem_byte, acc, imm, bit_sel,
    input  result, result_zero, skip, writes_acc, writes_mem, writes_zero
  );
  modport alu (
    input  op, mem_byte, acc, imm, bit_sel,
    output result, result_zero, skip, writes_acc, writes_mem, writes_zero
  );
endinterface

/* File: rtl/stx_alu.sv */
`timescale 1ns/100ps
module stx_alu #(
  parameter int DATA_W = stx_pkg::DATA_W
) (
  // Operands in, result and write enables out
  stx_op_if.alu opi
);
  localparam int HALF = DATA_W / 2;

  function automatic logic f_is_zero(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction

  always_comb begin
    opi.result      = '0;
    opi.skip        = 1'b0;
    opi.writes_acc  = 1'b0;
    opi.writes_mem  = 1'b0;
    opi.writes_zero = 1'b0;
    case (opi.op)
      stx_pkg::OP_NIBBLE_SWAP_ACC: begin
        // Memory stays untouched, only the accumulator takes the swap
        opi.result     = {opi.mem_byte[HALF-1:0], opi.mem_byte[DATA_W-1:HALF]};
        opi.writes_acc = 1'b1;
      end
      stx_pkg::OP_SKIP_IF_ZERO: begin
        opi.skip = f_is_zero(opi.mem_byte);
      end
      stx_pkg::OP_MOVE_SKIP_ZERO: begin
        opi.result     = opi.mem_byte;
        opi.writes_acc = 1'b1;
        opi.skip       = f_is_zero(opi.mem_byte);
      end
      stx_pkg::OP_SKIP_BIT_CLEAR: begin
        opi.skip = ~opi.mem_byte[opi.bit_sel];
      end
      stx_pkg::OP_XOR_ACC_MEM: begin
        opi.result      = opi.acc ^ opi.mem_byte;
        opi.writes_acc  = 1'b1;
        opi.writes_zero = 1'b1;
      end
      stx_pkg::OP_XOR_TO_MEMORY: begin
        opi.result      = opi.acc ^ opi.mem_byte;
        opi.writes_mem  = 1'b1;
        opi.writes_zero = 1'b1;
      end
      stx_pkg::OP_XOR_IMM: begin
        opi.result      = opi.acc ^ opi.imm;
        opi.writes_acc  = 1'b1;
        opi.writes_zero = 1'b1;
      end
      default: begin
        opi.result = '0;
      end
    endcase
  end

  assign opi.result_zero = f_is_zero(opi.result);
endmodule

/* File: rtl/stx_exec.sv */
`timescale 1ns/100ps
// Function
// - Swap to accumulator: low nibble from bits 7..4, high nibble from bits 3..0.
// - Byte test: zero byte discards prefetch, dummy cycle, 2 cycles; else 1 cycle.
// - Move-and-skip copies byte to accumulator; zero byte also skips, 2 cycles.
// - Bit test: selected bit clear discards prefetch, 2 cycles; else 1 cycle.
// - Current-page table read: low byte to memory, high byte to latch.
// - Last-page table read: low byte to memory, high byte to latch.
// - Accumulator xor memory into accumulator, zero flag from result.
// - Xor to memory writes back the byte, only zero flag changes.
// - Accumulator xor immediate into accumulator, zero flag updated.
// - Swap to accumulator leaves the data byte unmodified.
module stx_exec #(
  parameter int DATA_W  = stx_pkg::DATA_W,
  parameter int PROG_W  = stx_pkg::PROG_W,
  parameter int PROG_AW = stx_pkg::PROG_AW,
  parameter int PAGE_W  = stx_pkg::PAGE_W,
  parameter int MEM_AW  = stx_pkg::MEM_AW,
  parameter int BIT_W   = stx_pkg::BIT_W
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  // Instruction request
  input  wire logic                        op_valid,
  output logic                             op_ready,
  input  wire stx_pkg::stx_op_t            op_code,
  input  wire logic [MEM_AW-1:0]           op_addr,
  input  wire logic [BIT_W-1:0]            op_bit,
  input  wire logic [DATA_W-1:0]           op_imm,
  input  wire logic [DATA_W-1:0]           mem_rdata,
  // Table addressing
  input  wire logic [PAGE_W-1:0]           pc_page,
  input  wire logic [PROG_AW-PAGE_W-1:0]   table_pointer,
  // Program memory port
  output logic                             prog_req,
  output logic [PROG_AW-1:0]               prog_addr,
  input  wire logic [PROG_W-1:0]           prog_rdata,
  input  wire logic                        prog_ack,
  // Data memory write port
  output logic                             mem_we,
  output logic [MEM_AW-1:0]                mem_waddr,
  output logic [DATA_W-1:0]                mem_wdata,
  // Core state
  output logic [DATA_W-1:0]                acc,
  output logic [PROG_W-DATA_W-1:0]         table_high_latch,
  output logic                             zero_flag,
  output logic                             skip_flush,
  output logic                             done
);
  localparam int HIGH_W = PROG_W - DATA_W;
  localparam int HALF   = DATA_W / 2;

  logic                       rst_meta_reg;
  logic                       rst_sync_reg;
  logic                       rst_n;
  stx_pkg::stx_state_t        state_reg;
  stx_pkg::stx_state_t        state_next;
  logic                       take;
  logic                       table_op;
  logic                       table_done;
  logic [DATA_W-1:0]          acc_reg;
  logic [HIGH_W-1:0]          high_reg;
  logic                       zero_reg;
  logic                       mem_we_reg;
  logic [MEM_AW-1:0]          mem_waddr_reg;
  logic [DATA_W-1:0]          mem_wdata_reg;
  logic [PROG_AW-1:0]         prog_addr_reg;
  logic                       done_reg;

  stx_op_if #(.DATA_W(DATA_W), .BIT_W(BIT_W)) opi ();

  stx_alu #(.DATA_W(DATA_W)) stx_alu_i (
    .opi (opi.alu)
  );

  // Release reset synchronously so all flops reset by rst_n leave reset on one edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  assign opi.op       = op_code;
  assign opi.mem_byte = mem_rdata;
  assign opi.acc      = acc_reg;
  assign opi.imm      = op_imm;
  assign opi.bit_sel  = op_bit;

  assign op_ready   = (state_reg == stx_pkg::ST_IDLE);
  assign take       = op_valid && op_ready;
  assign table_op   = (op_code == stx_pkg::OP_TABLE_READ_CUR) ||
                      (op_code == stx_pkg::OP_TABLE_READ_LAST);
  assign table_done = (state_reg == stx_pkg::ST_TABLE) && prog_ack;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      stx_pkg::ST_IDLE: begin
        if (take && opi.skip) begin
          state_next = stx_pkg::ST_DUMMY;
        end else if (take && table_op) begin
          state_next = stx_pkg::ST_TABLE;
        end
      end
      stx_pkg::ST_DUMMY: begin
        state_next = stx_pkg::ST_IDLE;
      end
      stx_pkg::ST_TABLE: begin
        if (prog_ack) begin
          state_next = stx_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = stx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= stx_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= stx_pkg::ACC_RESET[DATA_W-1:0];
    end else if (take && opi.writes_acc) begin
      acc_reg <= opi.result;
    end
  end

  // Only the xor group touches the flag; every other op holds it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_reg <= stx_pkg::ZERO_RESET;
    end else if (take && opi.writes_zero) begin
      zero_reg <= opi.result_zero;
    end
  end

  // Table pointer selects the word within the current or the last page
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_addr_reg <= '0;
    end else if (take && op_code == stx_pkg::OP_TABLE_READ_LAST) begin
      prog_addr_reg <= {{PAGE_W{1'b1}}, table_pointer};
    end else if (take && op_code == stx_pkg::OP_TABLE_READ_CUR) begin
      prog_addr_reg <= {pc_page, table_pointer};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_reg <= stx_pkg::HIGH_RESET[HIGH_W-1:0];
    end else if (table_done) begin
      high_reg <= prog_rdata[PROG_W-1:DATA_W];
    end
  end

  // Destination address held through the table fetch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we_reg    <= 1'b0;
      mem_waddr_reg <= '0;
      mem_wdata_reg <= '0;
    end else begin
      mem_we_reg <= (take && opi.writes_mem) || table_done;
      if (take) begin
        mem_waddr_reg <= op_addr;
      end
      if (table_done) begin
        mem_wdata_reg <= prog_rdata[DATA_W-1:0];
      end else if (take && opi.writes_mem) begin
        mem_wdata_reg <= opi.result;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (take && !table_op) || table_done;
    end
  end

  assign acc              = acc_reg;
  assign zero_flag        = zero_reg;
  assign table_high_latch = high_reg;
  assign mem_we           = mem_we_reg;
  assign mem_waddr        = mem_waddr_reg;
  assign mem_wdata        = mem_wdata_reg;
  assign prog_addr        = prog_addr_reg;
  assign prog_req         = (state_reg == stx_pkg::ST_TABLE);
  // Dummy slot stands in for the discarded prefetch
  assign skip_flush       = (state_reg == stx_pkg::ST_DUMMY);
  assign done             = done_reg;

  property p_swap;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_NIBBLE_SWAP_ACC |=>
      acc == {$past(mem_rdata[HALF-1:0]), $past(mem_rdata[DATA_W-1:HALF])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap result wrong");

  property p_skip_zero;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_SKIP_IF_ZERO && mem_rdata == '0 |=>
      skip_flush && !op_ready ##1 !skip_flush && op_ready;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("zero byte skip wrong");

  property p_no_skip;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_SKIP_IF_ZERO && mem_rdata != '0 |=> !skip_flush && op_ready;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("nonzero byte skipped");

  property p_move_skip;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_MOVE_SKIP_ZERO |=>
      acc == $past(mem_rdata) && skip_flush == ($past(mem_rdata) == '0);
  endproperty
  a_move_skip: assert property (p_move_skip) else $error("move skip wrong");

  property p_bit_skip;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_SKIP_BIT_CLEAR |=>
      skip_flush == !$past(mem_rdata[op_bit]);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

  property p_table_cur;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_TABLE_READ_CUR |=>
      prog_req && prog_addr == {$past(pc_page), $past(table_pointer)};
  endproperty
  a_table_cur: assert property (p_table_cur) else $error("current page address wrong");

  property p_table_last;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_TABLE_READ_LAST |=>
      prog_req && prog_addr == {{PAGE_W{1'b1}}, $past(table_pointer)};
  endproperty
  a_table_last: assert property (p_table_last) else $error("last page address wrong");

  property p_table_write;
    @(posedge core_clk) disable iff (!rst_n)
    table_done |=> mem_we && mem_wdata == $past(prog_rdata[DATA_W-1:0]) &&
      table_high_latch == $past(prog_rdata[PROG_W-1:DATA_W]) && $stable(zero_flag);
  endproperty
  a_table_write: assert property (p_table_write) else $error("table word split wrong");

  property p_xor_acc;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_XOR_ACC_MEM |=>
      acc == ($past(acc) ^ $past(mem_rdata)) && zero_flag == (acc == '0);
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor to acc wrong");

  property p_xor_mem;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_XOR_TO_MEMORY |=> mem_we && $stable(acc) &&
      mem_wdata == ($past(acc) ^ $past(mem_rdata)) && zero_flag == (mem_wdata == '0);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

  property p_xor_imm;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_XOR_IMM |=>
      acc == ($past(acc) ^ $past(op_imm)) && zero_flag == (acc == '0) && !mem_we;
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");

  property p_swap_keeps_mem;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code == stx_pkg::OP_NIBBLE_SWAP_ACC |=> !mem_we;
  endproperty
  a_swap_keeps_mem: assert property (p_swap_keeps_mem) else $error("swap wrote memory");

  property p_flags_hold;
    @(posedge core_clk) disable iff (!rst_n)
    take && op_code inside {stx_pkg::OP_NIBBLE_SWAP_ACC, stx_pkg::OP_SKIP_IF_ZERO,
      stx_pkg::OP_MOVE_SKIP_ZERO, stx_pkg::OP_SKIP_BIT_CLEAR, stx_pkg::OP_TABLE_READ_CUR,
      stx_pkg::OP_TABLE_READ_LAST} |=> $stable(zero_flag);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("zero flag changed");
endmodule

/* File: testbench/skip_table_xor_exec_test.sv */
`timescale 1ns/100ps
module skip_table_xor_exec_test;
  // Clock, reset and request
  logic                                         core_clk;
  logic                                         resetn;
  logic                                         op_valid;
  logic                                         op_ready;
  stx_pkg::stx_op_t                             op_code;
  logic [stx_pkg::MEM_AW-1:0]                   op_addr;
  logic [stx_pkg::BIT_W-1:0]                    op_bit;
  logic [stx_pkg::DATA_W-1:0]                   op_imm;
  logic [stx_pkg::DATA_W-1:0]                   mem_rdata;
  // Table and program port
  logic [stx_pkg::PAGE_W-1:0]                   pc_page;
  logic [stx_pkg::PROG_AW-stx_pkg::PAGE_W-1:0]  table_pointer;
  logic                                         prog_req;
  logic [stx_pkg::PROG_AW-1:0]                  prog_addr;
  logic [stx_pkg::PROG_W-1:0]                   prog_rdata;
  logic                                         prog_ack;
  // Results
  logic                                         mem_we;
  logic [stx_pkg::MEM_AW-1:0]                   mem_waddr;
  logic [stx_pkg::DATA_W-1:0]                   mem_wdata;
  logic [stx_pkg::DATA_W-1:0]                   acc;
  logic [stx_pkg::PROG_W-stx_pkg::DATA_W-1:0]   table_high_latch;
  logic                                         zero_flag;
  logic                                         skip_flush;
  logic                                         done;
  // Bench state
  int                                           bad_count;
  int                                           cmp_count;
  int                                           seed_ret;
  logic [7:0]                                   exp_acc;
  logic [5:0]                                   exp_hi;
  logic                                         exp_z;

  stx_exec stx_exec_i (
    .core_clk(core_clk), .resetn(resetn), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm),
    .mem_rdata(mem_rdata), .pc_page(pc_page), .table_pointer(table_pointer),
    .prog_req(prog_req), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .prog_ack(prog_ack), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .acc(acc), .table_high_latch(table_high_latch), .zero_flag(zero_flag),
    .skip_flush(skip_flush), .done(done)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] f_res(stx_pkg::stx_op_t op, logic [7:0] a, logic [7:0] m,
                                       logic [7:0] imm);
    case (op)
      stx_pkg::OP_NIBBLE_SWAP_ACC: return {m[3:0], m[7:4]};
      stx_pkg::OP_MOVE_SKIP_ZERO:  return m;
      stx_pkg::OP_XOR_IMM:         return a ^ imm;
      default:                     return a ^ m;
    endcase
  endfunction

  function automatic logic f_skip(stx_pkg::stx_op_t op, logic [7:0] m, logic [2:0] b);
    if (op == stx_pkg::OP_SKIP_IF_ZERO || op == stx_pkg::OP_MOVE_SKIP_ZERO) return m == 8'h00;
    if (op == stx_pkg::OP_SKIP_BIT_CLEAR) return m[b] == 1'b0;
    return 1'b0;
  endfunction

  task automatic run_op(input stx_pkg::stx_op_t op, input logic [7:0] byt, input logic [7:0] imm,
                        input logic [2:0] bsel, input logic [13:0] word, input int wait_n);
    logic        skip;
    logic        we;
    logic        tbl;
    logic [7:0]  res;
    logic [7:0]  wdata;
    logic [10:0] paddr;
    int          n;
    @(posedge core_clk);
    #1;
    op_valid = 1'b1;
    op_code = op;
    op_addr = 7'($urandom);
    op_bit = bsel;
    op_imm = imm;
    mem_rdata = byt;
    pc_page = 3'($urandom);
    table_pointer = 8'($urandom);
    tbl = (op == stx_pkg::OP_TABLE_READ_CUR) || (op == stx_pkg::OP_TABLE_READ_LAST);
    paddr = (op == stx_pkg::OP_TABLE_READ_LAST) ? {{stx_pkg::PAGE_W{1'b1}}, table_pointer}
                                                : {pc_page, table_pointer};
    skip = f_skip(op, byt, bsel);
    res = f_res(op, exp_acc, byt, imm);
    we = tbl || (op == stx_pkg::OP_XOR_TO_MEMORY);
    wdata = tbl ? word[7:0] : res;
    if (tbl) exp_hi = word[13:8];
    if (op inside {stx_pkg::OP_XOR_ACC_MEM, stx_pkg::OP_XOR_TO_MEMORY, stx_pkg::OP_XOR_IMM})
      exp_z = (res == 8'h00);
    if (op inside {stx_pkg::OP_NIBBLE_SWAP_ACC, stx_pkg::OP_MOVE_SKIP_ZERO,
                   stx_pkg::OP_XOR_ACC_MEM, stx_pkg::OP_XOR_IMM}) exp_acc = res;
    n = 0;
    @(negedge core_clk);
    while (op_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 20) bad_count++;
    @(posedge core_clk);
    #1;
    op_valid = 1'b0;
    mem_rdata = ~byt;
    if (tbl) begin
      prog_rdata = word;
      prog_ack = (wait_n == 0);
      for (n = 0; n <= wait_n; n++) begin
        @(negedge core_clk);
        chk("prog_req", prog_req, 1'b1);
        chk("prog_addr", prog_addr, paddr);
        chk("early done", done, 1'b0);
        @(posedge core_clk);
        #1;
        prog_ack = (n + 1 == wait_n);
      end
      prog_rdata = ~word;
    end
    @(negedge core_clk);
    chk("done", done, 1'b1);
    chk("skip_flush", skip_flush, skip);
    chk("op_ready", op_ready, !skip);
    chk("mem_we", mem_we, we);
    if (we) chk("mem_waddr", mem_waddr, op_addr);
    if (we) chk("mem_wdata", mem_wdata, wdata);
    chk("acc", acc, exp_acc);
    chk("zero_flag", zero_flag, exp_z);
    chk("table_high_latch", table_high_latch, exp_hi);
    if (skip) begin
      @(negedge core_clk);
      chk("flush end", skip_flush, 1'b0);
      chk("ready after dummy", op_ready, 1'b1);
      chk("done end", done, 1'b0);
    end
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    stx_pkg::stx_op_t rop;
    logic [7:0]       rb;
    bad_count = 0;
    cmp_count = 0;
    resetn = 1'b0;
    op_valid = 1'b0;
    op_code = stx_pkg::OP_IDLE;
    op_addr = 7'h00;
    op_bit = 3'h0;
    op_imm = 8'h00;
    mem_rdata = 8'h00;
    pc_page = 3'h0;
    table_pointer = 8'h00;
    prog_rdata = 14'h0000;
    prog_ack = 1'b0;
    exp_acc = stx_pkg::ACC_RESET;
    exp_hi = stx_pkg::HIGH_RESET[5:0];
    exp_z = stx_pkg::ZERO_RESET;
    seed_ret = $urandom(32'h3cb38e89);
    repeat (4) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("reset acc", acc, stx_pkg::ACC_RESET);
    chk("reset latch", table_high_latch, stx_pkg::HIGH_RESET[5:0]);
    chk("reset zero", zero_flag, stx_pkg::ZERO_RESET);
    chk("reset ready", op_ready, 1'b1);
    // Corner cases first, flags left set to expose stray writes
    run_op(stx_pkg::OP_NIBBLE_SWAP_ACC, 8'ha5, 8'h00, 3'h0, 14'h0, 0);
    run_op(stx_pkg::OP_XOR_IMM, 8'h00, 8'h5a, 3'h0, 14'h0, 0);
    run_op(stx_pkg::OP_NIBBLE_SWAP_ACC, 8'h3c, 8'h00, 3'h0, 14'h0, 0);
    run_op(stx_pkg::OP_SKIP_IF_ZERO, 8'h00, 8'h00, 3'h0, 14'h0, 0);
    run_op(stx_pkg::OP_SKIP_IF_ZERO, 8'h01, 8'h00, 3'h0, 14'h0, 0);
    run_op(stx_pkg::OP_MOVE_SKIP_ZERO, 8'h00, 8'h00, 3'h0, 14'h0, 0);
    run_op(stx_pkg::OP_MOVE_SKIP_ZERO, 8'h80, 8'h00, 3'h0, 14'h0, 0);
    for (int i = 0; i < 8; i++) begin
      run_op(stx_pkg::OP_SKIP_BIT_CLEAR, ~(8'h01 << i), 8'h00, 3'(i), 14'h0, 0);
      run_op(stx_pkg::OP_SKIP_BIT_CLEAR, 8'h01 << i, 8'h00, 3'(i), 14'h0, 0);
    end
    run_op(stx_pkg::OP_TABLE_READ_CUR, 8'h00, 8'h00, 3'h0, 14'h3fff, 0);
    run_op(stx_pkg::OP_TABLE_READ_LAST, 8'h00, 8'h00, 3'h0, 14'h1234, 3);
    run_op(stx_pkg::OP_XOR_ACC_MEM, exp_acc, 8'h00, 3'h0, 14'h0, 0);
    run_op(stx_pkg::OP_XOR_TO_MEMORY, 8'h81, 8'h00, 3'h0, 14'h0, 0);
    // Random mix, zero bytes made common so skips happen often
    for (int k = 0; k < 300; k++) begin
      rop = stx_pkg::stx_op_t'($urandom_range(9, 1));
      rb = ($urandom_range(3, 0) == 0) ? 8'h00 : 8'($urandom);
      run_op(rop, rb, 8'($urandom), 3'($urandom), 14'($urandom), $urandom_range(4, 0));
    end
    end_of_test();
  end
endmodule
